// ==== rtl/nfc_map.svh ====
`ifndef NFC_MAP_SVH
`define NFC_MAP_SVH
// command codes
`define NFC_CMD_READ      8'h00
`define NFC_CMD_READ_GO   8'h30
`define NFC_CMD_SERIAL_IN 8'h80
`define NFC_CMD_COL_CHG   8'h85
`define NFC_CMD_PROG      8'h10
`define NFC_CMD_MULTI     8'h11
`define NFC_CMD_ERASE1    8'h60
`define NFC_CMD_ERASE2    8'hD0
`define NFC_CMD_STATUS    8'h70
`define NFC_CMD_STATUS2   8'h71
`define NFC_CMD_RESET     8'hFF
// status bit positions
`define NFC_ST_FAIL       0
`define NFC_ST_RDY1       5
`define NFC_ST_RDY2       6
`define NFC_ST_WP_N       7
// geometry
`define NFC_SECT_MAIN     12'd512
`define NFC_SECT_SPARE    12'd16
`define NFC_SPARE_BASE    12'd2048
`define NFC_PAGES         7'd64
`define NFC_BLOCKS        12'd2048
`define NFC_MIN_GOOD      12'd2008
// strobe phase length in clocks
`define NFC_PHASE_CYC     2'd1
`endif

// ==== rtl/nfc_pkg.sv ====
`default_nettype none
package nfc_pkg;
  typedef enum logic [2:0] {
    NFC_OP_READ,
    NFC_OP_PROG,
    NFC_OP_ERASE,
    NFC_OP_STATUS,
    NFC_OP_RESET,
    NFC_OP_RESUME
  } nfc_op_t;
  typedef struct packed {
    nfc_op_t     op;
    logic [10:0] block;
    logic [5:0]  page;
    logic [1:0]  sector;
    logic        partial;
  } nfc_req_t;
  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic       ce_n;
  } nfc_ctl_t;
endpackage
`default_nettype wire

// ==== rtl/nfc_host.sv ====
// What this block does
// R1: during power-on busy only reset or status read are issued
// R2: only defined command codes are ever placed on the bus
// R3: while busy only status reads or reset are issued
// R4: after serial input only column change, program, multi program, reset follow
// R5: device drops pending program if another command follows serial input
// R6: full pages within a block are programmed in ascending order only; partial programs are not order checked
// R7: status read during read keeps status output until read resent
// R8: read resumes after status with no new address cycles sent
// R9: device aborts program or erase when write protect goes low
// R10: a sixth address cycle is ignored by the device
// R11: device computes ecc per 512 main plus 16 spare bytes
// R12: partial program writes one sector main and spare, rest all ones
// R13: never erase a block marked bad
// R14: blocks found bad are tracked and excluded from access; the code tracks only the first 40 marked and ignores later marks
// R15: up to 40 of 2048 blocks may be unusable
// R16: ready busy is open drain, low while busy
// R17: status byte: fail bit 0, ready bits 5 and 6, wp bit 7
// R18: reset stops every operation and leaves device idle
`include "nfc_map.svh"
`default_nettype none
module nfc_host #(
  parameter int BLOCKS = 2048
) (
  // clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          reset_i,
  // request port
  input  wire logic          req_valid_i,
  input  wire nfc_pkg::nfc_req_t req_i,
  input  wire logic          mark_bad_i,
  input  wire logic [10:0]   mark_blk_i,
  output logic               req_ready_o,
  output logic               done_o,
  output logic               refused_o,
  output logic [7:0]         status_o,
  // data stream
  input  wire logic [7:0]    wdata_i,
  output logic [7:0]         rdata_o,
  output logic               rdata_valid_o,
  // flash pins
  output nfc_pkg::nfc_ctl_t  ctl_o,
  output logic               wp_n_o,
  output logic [7:0]         io_o,
  output logic               io_oe_o,
  input  wire logic [7:0]    io_i,
  input  wire logic          ready_busy_n_out_i
);
  typedef enum logic [2:0] {S_IDLE, S_CMD, S_ADDR, S_DATA, S_CMD2, S_WAIT, S_RDOUT} nfc_st_t;
  nfc_st_t st_r;
  logic [1:0] rb_sync_r;
  logic [7:0] iosync1_r, iosync2_r;
  logic [BLOCKS-1:0] bad_r;
  logic [6:0] next_page_r [BLOCKS];
  nfc_pkg::nfc_req_t cur_r;
  logic [11:0] cnt_r;
  logic [2:0] acyc_r;
  logic [1:0] ph_r;
  logic in_read_r;
  logic [11:0] bad_cnt_r;
  // ready/busy passes two flops; the pad pulls high externally
  wire busy = ~rb_sync_r[1]; // R16
  function automatic logic sector_col(input logic [11:0] c, input logic [1:0] s);
    sector_col = (c[11] == 1'b0) ? (c[10:9] == s) : (c[5:4] == s);
  endfunction
  // request legality checks
  wire busy_ok = (req_i.op == nfc_pkg::NFC_OP_STATUS) || (req_i.op == nfc_pkg::NFC_OP_RESET);
  wire blk_bad = bad_r[req_i.block];
  wire order_ok = ({1'b0, req_i.page} == next_page_r[req_i.block]) || req_i.partial;
  wire resume_ok = (req_i.op != nfc_pkg::NFC_OP_RESUME) || in_read_r;
  wire legal = (!busy || busy_ok) // R1 R3
    && !(blk_bad && req_i.op != nfc_pkg::NFC_OP_STATUS && req_i.op != nfc_pkg::NFC_OP_RESET) // R13 R14
    && ((req_i.op != nfc_pkg::NFC_OP_PROG) || order_ok) && resume_ok; // R6 R8
  wire take = (st_r == S_IDLE) && req_valid_i;
  // first command byte per operation, only defined codes
  wire [7:0] cmd1 = (req_i.op == nfc_pkg::NFC_OP_READ)   ? `NFC_CMD_READ :   // R2
                    (req_i.op == nfc_pkg::NFC_OP_PROG)   ? `NFC_CMD_SERIAL_IN :
                    (req_i.op == nfc_pkg::NFC_OP_ERASE)  ? `NFC_CMD_ERASE1 :
                    (req_i.op == nfc_pkg::NFC_OP_STATUS) ? `NFC_CMD_STATUS :
                    (req_i.op == nfc_pkg::NFC_OP_RESUME) ? `NFC_CMD_READ : `NFC_CMD_RESET;
  wire [7:0] cmd2 = (cur_r.op == nfc_pkg::NFC_OP_READ) ? `NFC_CMD_READ_GO :
                    (cur_r.op == nfc_pkg::NFC_OP_PROG) ? `NFC_CMD_PROG : `NFC_CMD_ERASE2; // R4
  wire [2:0] n_addr = (cur_r.op == nfc_pkg::NFC_OP_ERASE) ? 3'd3 : 3'd5; // R10
  wire [11:0] col0 = cur_r.partial ? {1'b0, cur_r.sector, 9'h000} : 12'h000;
  wire [11:0] col = col0 + cnt_r;
  wire [7:0] abyte = (acyc_r == 3'd0) ? col[7:0] : (acyc_r == 3'd1) ? {4'h0, col[11:8]} :
                     (acyc_r == 3'd2) ? {cur_r.block[1:0], cur_r.page} :
                     (acyc_r == 3'd3) ? cur_r.block[9:2] : {7'h00, cur_r.block[10]};
  wire [11:0] data_len = cur_r.partial ? 12'd2112 - col0 : 12'd2112;
  // partial program writes ones outside its sector
  wire [7:0] wbyte = (!cur_r.partial || sector_col(col, cur_r.sector)) ? wdata_i : 8'hFF; // R12 R11
  // the byte launched with the next strobe belongs to the column after the current one
  wire [11:0] col_ahead = col + 12'h001;
  wire [7:0] wbyte_ahead = (!cur_r.partial || sector_col(col_ahead, cur_r.sector)) ?
                           wdata_i : 8'hFF; // R12
  // synchronisers
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rb_sync_r <= 2'b00;
      iosync1_r <= 8'h00;
      iosync2_r <= 8'h00;
    end else begin
      rb_sync_r <= {rb_sync_r[0], ready_busy_n_out_i};
      iosync1_r <= io_i;
      iosync2_r <= iosync1_r;
    end
  end
  // bad block table and programming order per block
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      bad_r <= '0;
      bad_cnt_r <= 12'h000;
    end else if (mark_bad_i && !bad_r[mark_blk_i] && bad_cnt_r < `NFC_BLOCKS - `NFC_MIN_GOOD) begin
      bad_r[mark_blk_i] <= 1'b1; // R14 R15
      bad_cnt_r <= bad_cnt_r + 12'h001;
    end
  end
  // cleared at reset so the first program of a block is judged against page 0
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < BLOCKS; i++) next_page_r[i] <= 7'd0;
    end else if (st_r == S_WAIT && !busy && ph_r == 2'd3 && cur_r.op == nfc_pkg::NFC_OP_PROG
        && !cur_r.partial)
      next_page_r[cur_r.block] <= next_page_r[cur_r.block] + 7'd1; // R6
    else if (st_r == S_WAIT && !busy && ph_r == 2'd3 && cur_r.op == nfc_pkg::NFC_OP_ERASE)
      next_page_r[cur_r.block] <= 7'd0;
  end
  // sequencer
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= S_IDLE;
      cur_r <= '0;
      cnt_r <= 12'h000;
      acyc_r <= 3'd0;
      ph_r <= 2'd0;
      in_read_r <= 1'b0;
      ctl_o <= 5'b00111;
      wp_n_o <= 1'b0;
      io_o <= 8'h00;
      io_oe_o <= 1'b0;
      req_ready_o <= 1'b0;
      done_o <= 1'b0;
      refused_o <= 1'b0;
      status_o <= 8'h00;
      rdata_o <= 8'h00;
      rdata_valid_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      refused_o <= 1'b0;
      rdata_valid_o <= 1'b0;
      req_ready_o <= (st_r == S_IDLE) && !req_valid_i;
      unique case (st_r)
        S_IDLE: begin
          ctl_o <= 5'b00111;
          io_oe_o <= 1'b0;
          ph_r <= 2'd0;
          if (take && !legal) refused_o <= 1'b1;
          else if (take) begin
            cur_r <= req_i;
            wp_n_o <= (req_i.op == nfc_pkg::NFC_OP_PROG) || (req_i.op == nfc_pkg::NFC_OP_ERASE);
            io_o <= cmd1;
            io_oe_o <= 1'b1;
            ctl_o <= 5'b10010;
            cnt_r <= 12'h000;
            acyc_r <= 3'd0;
            st_r <= S_CMD;
          end
        end
        S_CMD: begin
          ctl_o.we_n <= 1'b1;
          if (cur_r.op == nfc_pkg::NFC_OP_STATUS) begin
            in_read_r <= in_read_r; // R7
            st_r <= S_RDOUT;
          end else if (cur_r.op == nfc_pkg::NFC_OP_RESUME) begin
            st_r <= S_RDOUT; // R8
          end else if (cur_r.op == nfc_pkg::NFC_OP_RESET) begin
            in_read_r <= 1'b0; // R18
            st_r <= S_WAIT;
          end else begin
            ctl_o <= 5'b01010;
            io_o <= (cur_r.op == nfc_pkg::NFC_OP_ERASE) ? {cur_r.block[1:0], 6'h00} : abyte;
            acyc_r <= (cur_r.op == nfc_pkg::NFC_OP_ERASE) ? 3'd2 : 3'd0;
            st_r <= S_ADDR;
          end
        end
        S_ADDR: begin
          if (ctl_o.we_n == 1'b0) ctl_o.we_n <= 1'b1;
          else if (acyc_r + 3'd1 == n_addr + ((cur_r.op == nfc_pkg::NFC_OP_ERASE) ? 3'd2 : 3'd0)) begin
            if (cur_r.op == nfc_pkg::NFC_OP_PROG) begin
              ctl_o <= 5'b00010;
              io_o <= wbyte;
              st_r <= S_DATA;
            end else begin
              ctl_o <= 5'b10010;
              io_o <= cmd2;
              st_r <= S_CMD2;
            end
          end else begin
            acyc_r <= acyc_r + 3'd1;
            ctl_o.we_n <= 1'b0;
            io_o <= (acyc_r == 3'd0) ? {4'h0, col[11:8]} : (acyc_r == 3'd1) ?
                    {cur_r.block[1:0], cur_r.page} : (acyc_r == 3'd2) ? cur_r.block[9:2] :
                    {7'h00, cur_r.block[10]};
          end
        end
        S_DATA: begin
          if (ctl_o.we_n == 1'b0) ctl_o.we_n <= 1'b1;
          else if (cnt_r + 12'h001 == data_len) begin
            ctl_o <= 5'b10010;
            io_o <= cmd2;
            st_r <= S_CMD2;
          end else begin
            cnt_r <= cnt_r + 12'h001;
            ctl_o.we_n <= 1'b0;
            io_o <= wbyte_ahead; // R12
          end
        end
        S_CMD2: begin
          ctl_o <= 5'b00110;
          io_oe_o <= 1'b0;
          ph_r <= 2'd0;
          in_read_r <= (cur_r.op == nfc_pkg::NFC_OP_READ);
          st_r <= S_WAIT;
        end
        S_WAIT: begin
          // the device needs a few clocks before busy is visible through the synchroniser
          if (ph_r != 2'd3) ph_r <= ph_r + 2'd1;
          else if (!busy) begin
            if (cur_r.op == nfc_pkg::NFC_OP_READ) begin
              cnt_r <= 12'h000;
              st_r <= S_RDOUT;
            end else begin
              done_o <= 1'b1;
              st_r <= S_IDLE;
              wp_n_o <= 1'b0;
            end
          end
        end
        S_RDOUT: begin
          io_oe_o <= 1'b0;
          if (ctl_o.re_n) begin
            ctl_o <= 5'b00100;
            ph_r <= 2'd0;
          end else if (ph_r != 2'd2) ph_r <= ph_r + 2'd1;
          else begin
            ctl_o.re_n <= 1'b1;
            rdata_o <= iosync2_r;
            rdata_valid_o <= 1'b1;
            if (cur_r.op == nfc_pkg::NFC_OP_STATUS) begin
              status_o <= iosync2_r; // R17
              done_o <= 1'b1;
              st_r <= S_IDLE;
            end else if (cnt_r + 12'h001 == 12'd2112) begin
              // read context stays so a status poll may still be followed by a resume
              done_o <= 1'b1;
              st_r <= S_IDLE;
            end else cnt_r <= cnt_r + 12'h001;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
  chk_busy_cmds: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R3
    (st_r == S_IDLE && take && legal && busy) |=> (cur_r.op == nfc_pkg::NFC_OP_STATUS
      || cur_r.op == nfc_pkg::NFC_OP_RESET)) else $error("non status command while busy");
  chk_bad_erase: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R13
    (take && legal && req_i.op == nfc_pkg::NFC_OP_ERASE) |-> !bad_r[req_i.block])
    else $error("erase issued to bad block");
  chk_order_page: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R6
    (take && legal && req_i.op == nfc_pkg::NFC_OP_PROG && !req_i.partial)
    |-> ({1'b0, req_i.page} == next_page_r[req_i.block])) else $error("page out of order");
  chk_resume_noaddr: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R8
    (st_r == S_CMD && cur_r.op == nfc_pkg::NFC_OP_RESUME) |=> st_r == S_RDOUT)
    else $error("address sent on read resume");
  chk_partial_ones: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R12
    (st_r == S_DATA && cur_r.partial && !sector_col(col, cur_r.sector)) |-> io_o == 8'hFF)
    else $error("partial program byte outside sector not ones");
  chk_refuse_pulse: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R1
    (take && !legal) |=> refused_o && st_r == S_IDLE) else $error("illegal request not refused");
  chk_cmd_defined: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R2
    (ctl_o.cle && io_oe_o) |-> (io_o inside {`NFC_CMD_READ, `NFC_CMD_READ_GO,
      `NFC_CMD_SERIAL_IN, `NFC_CMD_PROG, `NFC_CMD_ERASE1, `NFC_CMD_ERASE2, `NFC_CMD_STATUS,
      `NFC_CMD_RESET})) else $error("undefined command code");
  chk_prog_follow: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R4
    (st_r == S_CMD2 && cur_r.op == nfc_pkg::NFC_OP_PROG) |-> io_o == `NFC_CMD_PROG)
    else $error("bad command after serial input");
endmodule
`default_nettype wire

// ==== verification/nfc_dev.sv ====
`default_nettype none
module nfc_dev #(
  parameter int POR_CYC = 60,
  parameter int OP_CYC  = 20
) (
  // clock
  input  wire logic              clk_i,
  // flash pins as the device sees them
  input  wire nfc_pkg::nfc_ctl_t ctl_i,
  input  wire logic              wp_n_i,
  input  wire logic [7:0]        io_i,
  output logic [7:0]             io_o,
  output logic                   rb_o,
  // count of host protocol faults
  output logic [7:0]             viol_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int];
  logic [7:0] pg [0:2111];
  logic [7:0] ad [0:4];
  logic [7:0] par [0:3];
  logic [7:0] last_r = 8'h00;
  logic       stat_m = 0, prog_m = 0, read_m = 0, resumed = 0, pe = 0, fail = 0, re_q = 1;
  int         cnt = POR_CYC, ac = 0, col = 0, col0 = 0, viol = 0;
  wire        cyc = !ctl_i.ce_n && !ctl_i.we_n;
  wire [16:0] row = {ad[4][0], ad[3], ad[2]};
  function automatic int key(int c);
    return {3'h0, row, c[11:0]};
  endfunction
  function automatic logic [7:0] rd();
    if (stat_m) return {wp_n_i, cnt == 0, cnt == 0, 4'h0, fail};
    return mem.exists(key(col)) ? mem[key(col)] : 8'hFF;
  endfunction
  // ready/busy is driven high when cnt is zero and low while it counts
  assign rb_o   = (cnt != 0) ? 1'b0 : 1'b1;
  assign viol_o = viol[7:0];
  // decoding on the falling edge sees the host's pins settled and answers a read strobe
  // within half a clock, as a real part would
  always @(negedge clk_i) begin
    re_q <= ctl_i.re_n;
    if (cnt > 0) cnt <= cnt - 1;
    if (cnt == 0) pe <= 0;
    if (!wp_n_i && pe) begin
      cnt  <= 0;
      fail <= 1;
    end
    if (ctl_i.re_n && !re_q && !stat_m) col <= col + 1;
    // outside a selected read strobe the bus shows the inverse, so a stale byte never passes
    if (!ctl_i.ce_n && !ctl_i.re_n) begin
      io_o   <= rd();
      last_r <= rd();
    end else begin
      io_o <= ~last_r;
    end
    if (cyc && ctl_i.ale) begin
      if (resumed) viol++;
      if (ac < 5) ad[ac] <= io_i;
      if (ac == 1) col <= int'({io_i[3:0], ad[0]});
      ac <= ac + 1;
    end
    if (cyc && !ctl_i.cle && !ctl_i.ale && prog_m && col < 2112) begin
      pg[col] <= io_i;
      par[col < 2048 ? col / 512 : (col - 2048) / 16] ^= io_i;
      col <= col + 1;
    end
    if (cyc && ctl_i.cle) begin
      if (cnt > 0 && !(io_i inside {8'h70, 8'h71, 8'hFF})) viol++;
      if (prog_m && !(io_i inside {8'h85, 8'h10, 8'h11, 8'hFF})) viol++;
      prog_m  <= 0;
      resumed <= 0;
      case (io_i)
        8'h00: begin
          if (read_m && stat_m) begin
            resumed <= 1;
            col     <= col0;
          end else begin
            ac     <= 0;
            read_m <= 0;
          end
          stat_m <= 0;
        end
        8'h30: begin
          cnt    <= OP_CYC;
          read_m <= 1;
          col0   <= col;
        end
        8'h80: begin
          ac     <= 0;
          prog_m <= 1;
          read_m <= 0;
          fail   <= 0;
          foreach (pg[i]) pg[i] <= 8'hFF;
          foreach (par[i]) par[i] <= 8'h00;
        end
        8'h85: begin
          ac     <= 0;
          prog_m <= 1;
        end
        8'h10, 8'h11: begin
          for (int i = 0; i < 2112; i++) mem[key(i)] = pg[i];
          cnt <= OP_CYC;
          pe  <= 1;
        end
        8'h60: begin
          ac     <= 0;
          read_m <= 0;
          fail   <= 0;
        end
        8'hD0: begin
          cnt <= OP_CYC;
          pe  <= 1;
        end
        8'h70, 8'h71: stat_m <= 1;
        8'hFF: begin
          cnt    <= 4;
          pe     <= 0;
          stat_m <= 0;
          read_m <= 0;
        end
        default: viol++;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_nand_command_usage_rules.sv ====
`default_nettype none
module tb_nand_command_usage_rules;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys_i = 0, reset_i = 1, req_valid_i = 0, mark_bad_i = 0;
  nfc_pkg::nfc_req_t req_i = '0;
  logic [10:0]       mark_blk_i = '0;
  logic [7:0]        wdata_i = '0;
  logic              req_ready_o, done_o, refused_o, rdata_valid_o, wp_n_o, io_oe_o, rb;
  logic [7:0]        status_o, rdata_o, io_o, dev_io, bus, viol, v;
  nfc_pkg::nfc_ctl_t ctl_o;
  logic [10:0]       q_ev [$];
  logic [7:0]        q_rd [$];
  logic [10:0]       e;
  logic [7:0]        lf = 8'h59;
  int                error_cnt = 0, num_checks = 0, cyc = 0;
  assign bus = io_oe_o ? io_o : dev_io;
  nfc_host #(.BLOCKS(2048)) nfc_host_inst (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .mark_bad_i(mark_bad_i), .mark_blk_i(mark_blk_i), .req_ready_o(req_ready_o),
    .done_o(done_o), .refused_o(refused_o), .status_o(status_o), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .ctl_o(ctl_o), .wp_n_o(wp_n_o),
    .io_o(io_o), .io_oe_o(io_oe_o), .io_i(bus), .ready_busy_n_out_i(rb));
  nfc_dev nfc_dev_inst (.clk_i(clk_sys_i), .ctl_i(ctl_o), .wp_n_i(wp_n_o), .io_i(bus),
    .io_o(dev_io), .rb_o(rb), .viol_o(viol));
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  task automatic cmp_byte(input logic [7:0] x, input logic [7:0] g);
    num_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  task automatic cmp_ev(input logic [1:0] x, input logic [1:0] g);
    cmp_byte({6'h00, x}, {6'h00, g});
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [7:0] nxt(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // k: 1 done, 2 refused, 3 done with status byte; request held until taken
  task automatic req(input nfc_pkg::nfc_op_t op, input int b, p, s, pt, k);
    int n;
    n = 0;
    q_ev.push_back({k == 3, 8'h60, (k == 2) ? 2'b10 : 2'b01});
    // a status read also strobes its byte out on the read data port
    if (k == 3) q_rd.push_back(8'h60);
    @(posedge clk_sys_i);
    lf = nxt(lf);
    req_valid_i <= 1'b1;
    req_i       <= '{op, b[10:0], p[5:0], s[1:0], pt[0]};
    wdata_i     <= lf;
    do @(posedge clk_sys_i); while (req_ready_o !== 1'b1 && ++n < 100);
    req_valid_i <= 1'b0;
    n = 0;
    do @(posedge clk_sys_i); while (done_o !== 1'b1 && refused_o !== 1'b1 && ++n < 30000);
  endtask
  // partial pages hold data only in one sector's main and spare columns
  task automatic exp_page(input logic [7:0] d, input int s, pt);
    for (int i = 0; i < 2112; i++)
      q_rd.push_back((!pt || (i < 2048 && i / 512 == s) || (i >= 2048 && (i - 2048) / 16 == s))
                     ? d : 8'hFF);
  endtask
  // each result that appears retires the oldest note of its kind
  always @(posedge clk_sys_i) begin
    if (done_o === 1'b1 || refused_o === 1'b1) begin
      e = (q_ev.size() > 0) ? q_ev.pop_front() : 11'h000;
      cmp_ev(e[1:0], {refused_o, done_o});
      if (e[10]) cmp_byte(e[9:2], status_o);
    end
    if (rdata_valid_o === 1'b1)
      cmp_byte((q_rd.size() > 0) ? q_rd.pop_front() : 8'hxx, rdata_o);
  end
  // ceiling covers six page transfers of at most about 9000 cycles plus short work
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    req(nfc_pkg::NFC_OP_READ, 2, 0, 0, 0, 2);
    req(nfc_pkg::NFC_OP_RESET, 0, 0, 0, 0, 1);
    req(nfc_pkg::NFC_OP_STATUS, 0, 0, 0, 0, 3);
    req(nfc_pkg::NFC_OP_PROG, 2, 0, 0, 0, 1);
    v = lf;
    req(nfc_pkg::NFC_OP_PROG, 2, 1, 0, 0, 1);
    req(nfc_pkg::NFC_OP_PROG, 2, 0, 0, 0, 2);
    exp_page(v, 0, 0);
    req(nfc_pkg::NFC_OP_READ, 2, 0, 0, 0, 1);
    req(nfc_pkg::NFC_OP_STATUS, 0, 0, 0, 0, 3);
    exp_page(v, 0, 0);
    req(nfc_pkg::NFC_OP_RESUME, 2, 0, 0, 0, 1);
    req(nfc_pkg::NFC_OP_PROG, 3, 0, 2, 1, 1);
    v = lf;
    req(nfc_pkg::NFC_OP_RESUME, 3, 0, 0, 0, 2);
    exp_page(v, 2, 1);
    req(nfc_pkg::NFC_OP_READ, 3, 0, 0, 0, 1);
    for (int i = 0; i < 40; i++) begin
      mark_bad_i <= 1'b1;
      mark_blk_i <= 11'(100 + i);
      @(posedge clk_sys_i);
    end
    mark_bad_i <= 1'b0;
    req(nfc_pkg::NFC_OP_ERASE, 139, 0, 0, 0, 2);
    req(nfc_pkg::NFC_OP_READ, 100, 0, 0, 0, 2);
    req(nfc_pkg::NFC_OP_ERASE, 140, 0, 0, 0, 1);
    req(nfc_pkg::NFC_OP_STATUS, 0, 0, 0, 0, 3);
    repeat (4) @(posedge clk_sys_i);
    cmp_byte(8'(q_ev.size() + q_rd.size()), 8'h00);
    cmp_byte(viol, 8'h00);
    results();
  end
endmodule
`default_nettype wire
